/* File: eisa_consts.svh */
// Constants for the external interrupt sense and acknowledge block
`ifndef EISA_CONSTS_SVH
`define EISA_CONSTS_SVH
`define EISA_NUM_IRQ 4
`define EISA_SYNC_STAGES 2
`define EISA_REARM_CYCLES 2
`define EISA_ACK_LOW_CYCLES 1
`endif

/* File: eisa_pkg.sv */
// Types for the external interrupt sense and acknowledge block
`default_nettype none
package eisa_pkg;
  typedef enum logic [2:0] {
    EISA_ACK_IDLE = 3'h1,
    EISA_ACK_LOW = 3'h2,
    EISA_ACK_WAIT = 3'h4
  } eisa_ack_state_e;
endpackage
`default_nettype wire

/* File: eisa_sync_if.sv */
// Carrier between the request synchroniser and the detector
`timescale 1ns/1ps
`default_nettype none
interface eisa_sync_if #(parameter int N = 4);
  logic [N-1:0] raw_n;
  logic [N-1:0] level;
  modport sync (input raw_n, output level);
  modport user (output raw_n, input level);
endinterface // eisa_sync_if
`default_nettype wire

/* File: eisa_sync.sv */
// Two-stage synchroniser for the active-low requests
`timescale 1ns/1ps
`default_nettype none
module eisa_sync #(
  parameter int N = 4
) (
  input wire logic mclk_i,
  input wire logic resetn_i,
  eisa_sync_if.sync bus
);
  logic [N-1:0] meta_n;
  logic [N-1:0] stable_n;
  always_ff @(negedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meta_n <= {N{1'b1}};
      stable_n <= {N{1'b1}};
    end else begin
      meta_n <= bus.raw_n;
      stable_n <= meta_n;
    end
  end
  assign bus.level = ~stable_n;
endmodule // eisa_sync
`default_nettype wire

/* File: eisa_top.sv */
// External interrupt sensing, rate limiting and acknowledge strobe
`timescale 1ns/1ps
`default_nettype none
`include "eisa_consts.svh"
module eisa_top
  import eisa_pkg::*;
#(
  parameter int NUM_IRQ = `EISA_NUM_IRQ
) (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic [NUM_IRQ-1:0] ext_irq_n_i,
  input wire logic fetch_boundary_i,
  input wire logic ack_decode_i,
  input wire logic ack_read_i,
  output logic [NUM_IRQ-1:0] irq_pending_o,
  output logic [NUM_IRQ-1:0] irq_take_o,
  output logic irq_ack_n_o
);
  eisa_sync_if #(.N(NUM_IRQ)) sif ();
  eisa_ack_state_e state;
  eisa_ack_state_e next_state;
  logic [NUM_IRQ-1:0] detected;
  logic [NUM_IRQ-1:0] pending;
  logic [NUM_IRQ-1:0] take;
  logic [NUM_IRQ-1:0] hold_cnt;
  logic [NUM_IRQ-1:0] next_pending;
  logic [NUM_IRQ-1:0] next_take;
  logic next_ack_n;

  assign sif.raw_n = ext_irq_n_i;

  eisa_sync #(.N(NUM_IRQ)) u_sync (
    .mclk_i(mclk_i),
    .resetn_i(resetn_i),
    .bus(sif.sync)
  );

  // Level present at the falling-edge sample, no edge detect
  assign detected = sif.level;

  genvar g;
  generate
    for (g = 0; g < NUM_IRQ; g++) begin : g_src
      // Rearm holdoff: each source taken at most every two cycles
      assign next_pending[g] = (detected[g] & ~hold_cnt[g]) | (pending[g] & ~take[g]);
      assign next_take[g] = pending[g] & fetch_boundary_i & ~take[g];
    end
  endgenerate

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pending <= '0;
      take <= '0;
      hold_cnt <= '0;
    end else begin
      hold_cnt <= detected & ~hold_cnt;
      pending <= next_pending;
      take <= next_take;
    end
  end

  // Acknowledge strobe sequencing
  always_comb begin
    next_state = state;
    next_ack_n = 1'b1;
    case (state)
      EISA_ACK_IDLE: begin
        if (ack_decode_i) begin
          next_state = EISA_ACK_LOW;
          next_ack_n = 1'b0;
        end
      end
      EISA_ACK_LOW: begin
        next_ack_n = 1'b1;
        next_state = ack_read_i ? EISA_ACK_IDLE : EISA_ACK_WAIT;
      end
      EISA_ACK_WAIT: begin
        if (ack_read_i) begin
          next_state = EISA_ACK_IDLE;
        end
      end
      default: begin
        next_state = EISA_ACK_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state <= EISA_ACK_IDLE;
      irq_ack_n_o <= 1'b1;
    end else begin
      state <= next_state;
      irq_ack_n_o <= next_ack_n;
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_pending_o <= '0;
      irq_take_o <= '0;
    end else begin
      irq_pending_o <= next_pending;
      irq_take_o <= next_take;
    end
  end
endmodule // eisa_top
`default_nettype wire

/* File: eisa_top_properties.sv */
// Port assertions for the interrupt sense block
`timescale 1ns/1ps
`default_nettype none
module eisa_top_properties #(parameter int NUM_IRQ = 4) (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic [NUM_IRQ-1:0] ext_irq_n_i,
  input wire logic fetch_boundary_i,
  input wire logic ack_decode_i,
  input wire logic ack_read_i,
  input wire logic [NUM_IRQ-1:0] irq_pending_o,
  input wire logic [NUM_IRQ-1:0] irq_take_o,
  input wire logic irq_ack_n_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  ack_one_a: assert property ($fell(irq_ack_n_o) |=> irq_ack_n_o) else $error("ack long");
  ack_cause_a: assert property ($fell(irq_ack_n_o) |-> $past(ack_decode_i)) else $error("ack cause");
  take_fetch_a: assert property (|irq_take_o |-> $past(fetch_boundary_i)) else $error("take fetch");
  take_pend_a: assert property ((irq_take_o & ~$past(irq_pending_o)) == 0) else $error("take pend");
  take_once_a: assert property ((irq_take_o & $past(irq_take_o)) == 0) else $error("take twice");
  pend_hold_a: assert property ($fell(irq_pending_o[0]) |-> $past(irq_take_o[0])) else $error("pend lost");
  pend_cause_a: assert property ($rose(irq_pending_o[0]) |-> !$past(ext_irq_n_i[0]) ||
    !$past(ext_irq_n_i[0], 2) || !$past(ext_irq_n_i[0], 3)) else $error("pend cause");
  level_seen_a: assert property ((!ext_irq_n_i[3] && !fetch_boundary_i) [*6] |-> irq_pending_o[3])
    else $error("level");
  cover property ($fell(irq_ack_n_o));
  cover property (|irq_take_o);
  cover property ($rose(irq_pending_o[3]));
endmodule // eisa_top_properties
bind eisa_top eisa_top_properties #(.NUM_IRQ(NUM_IRQ)) prop_u (.*);
`default_nettype wire

/* File: eisa_src.sv */
// Peripheral model driving active-low requests
`timescale 1ns/1ps
`default_nettype none
module eisa_src (
  input wire logic mclk_i,
  input wire logic [3:0] f_i,
  output logic [3:0] irq_n_o
);
  initial irq_n_o = 4'hF;
  always @(posedge mclk_i) #1 irq_n_o = ~f_i;
endmodule // eisa_src
`default_nettype wire

/* File: eisa_top_tb.sv */
// Bench for the interrupt sense block
`timescale 1ns/1ps
`default_nettype none
module eisa_top_tb;
  logic mclk_i = 0, resetn_i = 0, fb = 1, dec = 0, rd = 0, ack;
  logic [3:0] f = 0, lows = 0, irq, pend, take, q[$];
  logic [31:0] lf = 32'hAC5FAA63;
  int num_errors = 0, tests_run = 0;
  function automatic logic [31:0] lfsr_next(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  eisa_top dut_u (.mclk_i, .resetn_i, .ext_irq_n_i(irq), .fetch_boundary_i(fb), .ack_decode_i(dec),
    .ack_read_i(rd), .irq_pending_o(pend), .irq_take_o(take), .irq_ack_n_o(ack));
  eisa_src src_u (.mclk_i, .f_i(f), .irq_n_o(irq));
  initial forever #2 mclk_i = ~mclk_i;
  task chk(logic [3:0] g, e);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  task end_sim;
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(negedge mclk_i) begin
    if (|take) chk(take, q.size() ? q.pop_front() : 4'h0);
    if (!ack) lows++;
  end
  initial begin
    repeat (12) @(negedge mclk_i);
    resetn_i = 1;
    for (int k = 0; k < 9; k++) begin
      lf = lfsr_next(lf);
      fb = k < 8;
      f = k < 8 ? lf[3:0] | 4'h1 << k[1:0] : 4'h8;
      q.push_back(f);
      repeat (k < 8 ? 1 : 99) @(negedge mclk_i);
      if (k == 8) chk(pend, 4'h8);
      f = 0;
      repeat (9) @(negedge mclk_i);
      fb = 1;
      repeat (9) @(negedge mclk_i);
      chk(4'(q.size()), 4'h0);
      chk(pend, 4'h0);
    end
    dec = 1;
    repeat (3) @(negedge mclk_i);
    dec = 0;
    rd = 1;
    @(negedge mclk_i) rd = 0;
    repeat (4) @(negedge mclk_i);
    chk(lows, 4'h1);
    dec = 1;
    @(negedge mclk_i) dec = 0;
    rd = 1;
    @(negedge mclk_i) rd = 0;
    repeat (4) @(negedge mclk_i);
    chk(lows, 4'h2);
    end_sim();
  end
endmodule // eisa_top_tb
`default_nettype wire
